// file: test/rtc_alarm_sva.sv
// Checker of the alarm block, seeing only its ports.
// Assumes one APB wait state and registers updated at the completing edge.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_sva
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [6:0]  time_seconds,
    input wire logic [6:0]  time_minutes,
    input wire logic [5:0]  time_hours,
    input wire logic        alarm_event
);
// ------------------------------------------------------------
// Shadow of the alarm registers
// ------------------------------------------------------------
logic [7:0] s_q;
logic [7:0] m_q;
logic [7:0] h_q;
wire take   = psel && penable && pready && pwrite && pstrb[0];
wire rd_end = psel && penable && pready && !pwrite;
wire sec_ok = !s_q[7] || s_q[6:0] == time_seconds;
wire min_ok = !m_q[7] || m_q[6:0] == time_minutes;
wire hr_ok  = !h_q[7] || h_q[5:0] == time_hours;
wire any_en = s_q[7] || m_q[7] || h_q[7];
wire match  = any_en && sec_ok && min_ok && hr_ok;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        {s_q, m_q, h_q} <= 24'h000000;
    else if (take)
        case (paddr)
            8'h00: s_q <= pwdata[7:0];
            8'h04: m_q <= pwdata[7:0];
            8'h08: h_q <= {pwdata[7], 1'b0, pwdata[5:0]};
            default: ;
        endcase
end
// ------------------------------------------------------------
// Assertions
// ------------------------------------------------------------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
a_pready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
a_event_on_match: assert property (match && !$past(match) |=> alarm_event)
    else $error("match without alarm event");
a_event_pulse: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
a_none_quiet: assert property (alarm_event |-> $past(any_en))
    else $error("alarm event with no field enabled");
a_sec_gate: assert property (alarm_event |-> $past(sec_ok))
    else $error("alarm event with seconds mismatch");
a_min_gate: assert property (alarm_event |-> $past(min_ok))
    else $error("alarm event with minutes mismatch");
a_hr_gate: assert property (alarm_event |-> $past(hr_ok))
    else $error("alarm event with hours mismatch");
a_hr_bit_six: assert property (rd_end && paddr == 8'h08 |-> !prdata[6])
    else $error("unused hours bit reads one");
endmodule // rtc_alarm_sva
bind rtc_time_alarm_compare rtc_alarm_sva i_sva
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .time_seconds, .time_minutes, .time_hours, .alarm_event
);
`default_nettype wire

// file: test/tb_rtc_time_alarm_compare.sv
// Self-checking bench of the alarm block over APB.
// Assumes the design's register offsets and one wait state.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_time_alarm_compare;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
logic alarm_event, irq, hour_format_24_select;
logic [7:0] paddr, n_ev;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb;
logic [6:0] time_seconds, time_minutes;
logic [5:0] time_hours;
int n_fail, checks_done;
rtc_time_alarm_compare i_dut
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .time_seconds, .time_minutes, .time_hours,
    .hour_format_24_select, .alarm_event, .irq
);
initial
begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
end
always @(posedge pclk)
begin
    if (!presetn)
        n_ev <= 8'h00;
    else if (alarm_event === 1'b1)
        n_ev <= n_ev + 8'h01;
end
// ------------------------------------------------------------
// Tasks
// ------------------------------------------------------------
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        n_fail++;
        $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
endtask
task tm(input logic [6:0] s, input logic [6:0] m, input logic [5:0] h);
    @(posedge pclk);
    {time_seconds, time_minutes, time_hours} <= {s, m, h};
    repeat (3) @(posedge pclk);
endtask
task results;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
initial
begin
    #100000;
    n_fail++;
    results;
end
// ------------------------------------------------------------
// Tests
// ------------------------------------------------------------
initial
begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {time_seconds, time_minutes, time_hours, hour_format_24_select} = '0;
    pstrb = 4'hf;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
        apb(1'b0, 8'(4 * i), 0);
        chk(rd, 0);
    end
    apb(1'b1, 8'h18, 0);
    chk(err, 1);
    apb(1'b1, 8'h10, 1);
    apb(1'b1, 8'h08, 8'hff);
    apb(1'b0, 8'h08, 0);
    chk(rd, 32'hbf);
    apb(1'b1, 8'h08, 0);
    pstrb <= 4'h0;
    apb(1'b1, 8'h00, 8'hd9);
    pstrb <= 4'hf;
    apb(1'b0, 8'h00, 0);
    chk(rd, 0);
    apb(1'b1, 8'h00, 8'hd9);
    apb(1'b0, 8'h00, 0);
    chk(rd, 32'hd9);
    tm(7'h59, 7'h00, 6'h00);
    tm(7'h59, 7'h00, 6'h00);
    chk(n_ev, 1);
    chk(irq, 1);
    apb(1'b0, 8'h14, 0);
    chk(rd, 1);
    apb(1'b1, 8'h0c, 1);
    apb(1'b0, 8'h0c, 0);
    chk(rd, 0);
    chk(irq, 0);
    apb(1'b1, 8'h04, 8'hd9);
    tm(7'h59, 7'h58, 6'h00);
    chk(n_ev, 1);
    tm(7'h59, 7'h59, 6'h00);
    chk(n_ev, 2);
    apb(1'b1, 8'h0c, 1);
    apb(1'b1, 8'h10, 0);
    apb(1'b1, 8'h08, 8'ha5);
    tm(7'h59, 7'h59, 6'h05);
    chk(n_ev, 2);
    tm(7'h59, 7'h59, 6'h25);
    chk(n_ev, 3);
    chk(irq, 0);
    apb(1'b0, 8'h0c, 0);
    chk(rd, 1);
    hour_format_24_select <= 1'b1;
    apb(1'b1, 8'h08, 8'ha3);
    tm(7'h59, 7'h59, 6'h23);
    chk(n_ev, 4);
    apb(1'b1, 8'h00, 8'h59);
    apb(1'b1, 8'h04, 8'h59);
    apb(1'b1, 8'h08, 8'h23);
    tm(7'h00, 7'h00, 6'h00);
    tm(7'h59, 7'h59, 6'h23);
    chk(n_ev, 4);
    apb(1'b0, 8'h14, 0);
    chk(rd, 0);
    results;
end
endmodule // tb_rtc_time_alarm_compare
`default_nettype wire

// file: verilog/rtc_alarm_defs.vh
// Register offsets, field positions and reset values of the alarm block.
// Assumes inclusion by bare name from design files.
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_ALARM_SECONDS 8'h00
`define OFF_ALARM_MINUTES 8'h04
`define OFF_ALARM_HOURS   8'h08
`define OFF_IRQ_STATUS    8'h0c
`define OFF_IRQ_MASK      8'h10
`define OFF_MATCH_STATE   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALARM_ENABLE_BIT  7
`define HOURS_UNUSED_BIT  6
`define HOURS_PM_BIT      5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ALARM_SECONDS 8'h00
`define RST_ALARM_MINUTES 8'h00
`define RST_ALARM_HOURS   8'h00
`define RST_IRQ_MASK      1'h0

`endif

// file: verilog/rtc_time_alarm_compare.v
// Alarm comparison of a real-time clock with an APB register slave.
// Assumes running time counts in BCD, synchronous to pclk.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_defs.vh"

module rtc_time_alarm_compare
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [6:0]  time_seconds,
    input  wire [6:0]  time_minutes,
    input  wire [5:0]  time_hours,
    input  wire        hour_format_24_select,
    output reg         alarm_event,
    output reg         irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  alarm_seconds_q;
    reg  [7:0]  alarm_minutes_q;
    reg  [7:0]  alarm_hours_q;
    reg         irq_status_q;
    reg         irq_mask_q;
    reg         match_q;

    // Bus qualifiers
    wire        access;
    wire        wr_en;
    wire        rd_en;
    wire        lane0;
    wire        addr_hit;

    // Register selects
    wire        sel_seconds;
    wire        sel_minutes;
    wire        sel_hours;
    wire        sel_status;
    wire        sel_mask;
    wire        sel_match;

    // Next values
    reg  [31:0] rdata_d;
    reg  [7:0]  alarm_seconds_d;
    reg  [7:0]  alarm_minutes_d;
    reg  [7:0]  alarm_hours_d;
    reg         irq_mask_d;
    reg         irq_status_d;
    reg         pready_d;
    reg         pslverr_d;
    reg  [31:0] prdata_d;
    reg         alarm_event_d;
    reg         irq_d;

    // First access cycle; the answer follows one edge later
    assign access = psel & penable & ~pready;
    // Writes take effect at the completing edge, with pready high
    assign wr_en  = psel & penable & pready & pwrite;
    assign rd_en  = access & ~pwrite;
    assign lane0  = pstrb[0];

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    wire        seconds_alarm_enable;
    wire        minutes_alarm_enable;
    wire        hours_alarm_enable;
    wire [6:0]  alarm_seconds_value;
    wire [6:0]  alarm_minutes_value;
    wire [5:0]  alarm_hours_value;
    wire        alarm_hour_pm_or_tens_bit;
    wire        sec_ok;
    wire        min_ok;
    wire        hr_ok;
    wire        any_en;
    wire        match_d;

    assign seconds_alarm_enable = alarm_seconds_q[`ALARM_ENABLE_BIT];
    assign minutes_alarm_enable = alarm_minutes_q[`ALARM_ENABLE_BIT];
    assign hours_alarm_enable   = alarm_hours_q[`ALARM_ENABLE_BIT];
    assign alarm_seconds_value  = alarm_seconds_q[6:0];
    assign alarm_minutes_value  = alarm_minutes_q[6:0];
    assign alarm_hours_value    = alarm_hours_q[5:0];
    assign alarm_hour_pm_or_tens_bit = alarm_hours_q[`HOURS_PM_BIT];

    // Seconds compare
    assign sec_ok = ~seconds_alarm_enable
                  | (alarm_seconds_value == time_seconds);
    // Minutes compare
    assign min_ok = ~minutes_alarm_enable
                  | (alarm_minutes_value == time_minutes);
    // 24h: full 5:0 compare; 12h: 4:0 plus PM flag, same bit position
    assign hr_ok  = ~hours_alarm_enable
                  | (hour_format_24_select
                     ? (alarm_hours_value == time_hours)
                     : ((alarm_hours_value[4:0] == time_hours[4:0])
                        & (alarm_hour_pm_or_tens_bit
                           == time_hours[`HOURS_PM_BIT])));
    assign any_en  = seconds_alarm_enable | minutes_alarm_enable
                   | hours_alarm_enable;
    assign match_d = any_en & sec_ok & min_ok & hr_ok;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign sel_seconds = (paddr == `OFF_ALARM_SECONDS);
    assign sel_minutes = (paddr == `OFF_ALARM_MINUTES);
    assign sel_hours   = (paddr == `OFF_ALARM_HOURS);
    assign sel_status  = (paddr == `OFF_IRQ_STATUS);
    assign sel_mask    = (paddr == `OFF_IRQ_MASK);
    assign sel_match   = (paddr == `OFF_MATCH_STATE);
    assign addr_hit    = sel_seconds | sel_minutes
                       | sel_hours | sel_status
                       | sel_mask | sel_match;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `OFF_ALARM_SECONDS:
            begin
                rdata_d = {24'h00_0000, alarm_seconds_q};
            end
            `OFF_ALARM_MINUTES:
            begin
                rdata_d = {24'h00_0000, alarm_minutes_q};
            end
            `OFF_ALARM_HOURS:
            begin
                rdata_d = {24'h00_0000, alarm_hours_q};
            end
            `OFF_IRQ_STATUS:
            begin
                rdata_d = {31'h0, irq_status_q};
            end
            `OFF_IRQ_MASK:
            begin
                rdata_d = {31'h0, irq_mask_q};
            end
            `OFF_MATCH_STATE:
            begin
                rdata_d = {31'h0, match_q};
            end
            // Unmapped offsets read as zero
            default:
            begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB response: one wait state, answer in second access cycle
    // ------------------------------------------------------------
    always @*
    begin
        pready_d  = access;
        pslverr_d = access & ~addr_hit;
        prdata_d  = 32'h0000_0000;
        if (rd_en)
        begin
            prdata_d = rdata_d;
        end
    end

    // Response outputs straight from flip-flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= pready_d;
            pslverr <= pslverr_d;
            prdata  <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Byte lane 0 carries every field; other lanes are ignored
    always @*
    begin
        alarm_seconds_d = alarm_seconds_q;
        alarm_minutes_d = alarm_minutes_q;
        alarm_hours_d   = alarm_hours_q;
        irq_mask_d      = irq_mask_q;
        if (wr_en && lane0)
        begin
            if (sel_seconds)
            begin
                alarm_seconds_d = pwdata[7:0];
            end
            if (sel_minutes)
            begin
                alarm_minutes_d = pwdata[7:0];
            end
            if (sel_hours)
            begin
                // Unused bit held at zero so it reads back as zero
                alarm_hours_d = {pwdata[7], 1'b0, pwdata[5:0]};
            end
            if (sel_mask)
            begin
                irq_mask_d = pwdata[0];
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_seconds_q <= `RST_ALARM_SECONDS;
            alarm_minutes_q <= `RST_ALARM_MINUTES;
            alarm_hours_q   <= `RST_ALARM_HOURS;
            irq_mask_q      <= `RST_IRQ_MASK;
        end
        else
        begin
            alarm_seconds_q <= alarm_seconds_d;
            alarm_minutes_q <= alarm_minutes_d;
            alarm_hours_q   <= alarm_hours_d;
            irq_mask_q      <= irq_mask_d;
        end
    end

    // ------------------------------------------------------------
    // Event, sticky status and interrupt
    // ------------------------------------------------------------
    wire rise;
    wire status_clr;

    // Edge of the match, so a standing match raises one event only
    assign rise       = match_d & ~match_q;
    assign status_clr = wr_en & lane0 & pwdata[0] & sel_status;

    always @*
    begin
        alarm_event_d = rise;
        // Set wins over a clear in the same cycle
        irq_status_d  = irq_status_q;
        if (status_clr)
        begin
            irq_status_d = 1'b0;
        end
        if (rise)
        begin
            irq_status_d = 1'b1;
        end
        // Level from next status and mask, so it tracks both at once
        irq_d = irq_status_d & irq_mask_d;
    end

    // Match history feeds the edge detector
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_q      <= 1'b0;
            alarm_event  <= 1'b0;
            irq_status_q <= 1'b0;
            irq          <= 1'b0;
        end
        else
        begin
            match_q      <= match_d;
            alarm_event  <= alarm_event_d;
            irq_status_q <= irq_status_d;
            irq          <= irq_d;
        end
    end

endmodule // rtc_time_alarm_compare

`default_nettype wire
